// *** core/eeprom_ctrl_pkg.sv ***
// Purpose: Constants and types for the EEPROM control register block
// Assumes: Byte-wide register port, 100 MHz clock
// Notes: Offsets are byte indices of the register port
//
// Functional notes
// - Divider readable; low bits write once, top fixed
// - Loaded bit reads 1 after first write
// - Prescale bit divides oscillator by eight first
// - Reserved test registers read zero, ignore writes
// - Config top two bits read/write, rest zero
// - Buffer-empty enable gates buffer-empty interrupt
// - Done enable gates command-done interrupt
// - Protection loaded from nonvolatile byte at reset
// - User nonvolatile flag bits are read only
// - Open and disable bits only clear by write
// - Size code writable only while disable set
// - Open bit zero protects whole array
// - Disable bit zero enables protected upper sector
// - Sector ends 0x7ff, size 64 times code+1
// - Protected program or erase refused, violation flagged
// - Mass erase only when open and disable set
// - Buffer-empty flag clears by writing one
// - Done flag sets when all commands finish
package eeprom_ctrl_pkg;
	localparam logic [3:0] off_divider = 4'h0;
	localparam logic [3:0] off_reserved_a = 4'h1;
	localparam logic [3:0] off_reserved_b = 4'h2;
	localparam logic [3:0] off_config = 4'h3;
	localparam logic [3:0] off_protection = 4'h4;
	localparam logic [3:0] off_status = 4'h5;
	localparam int bit_loaded = 7;
	localparam int bit_prescale = 6;
	localparam int bit_buf_irq_en = 7;
	localparam int bit_done_irq_en = 6;
	localparam int bit_open = 7;
	localparam int bit_range_dis = 3;
	localparam int bit_buf_empty = 7;
	localparam int bit_done = 6;
	localparam int bit_viol = 5;
	localparam logic [10:0] protection_byte_addr = 11'h7fd;
	localparam logic [10:0] array_top_addr = 11'h7ff;
	localparam logic [2:0] prescale_count = 3'h7;
	localparam logic [7:0] divider_reset = 8'h00;
	localparam logic [1:0] config_reset = 2'h0;
	localparam logic [7:0] zero_byte = 8'h00;

	typedef struct packed {
		logic valid;
		logic mass;
		logic [10:0] addr;
	} alter_req_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_load = 2'b01,
		st_run = 2'b10
	} prot_state_t;
endpackage

// *** core/algo_clock_div.sv ***
// Purpose: Algorithm clock tick generator from the oscillator rate
// Assumes: Oscillator equals the module clock
// Notes: Tick is a one-cycle pulse; stays high with divider zero and prescale off
`timescale 1ns/1ps
module algo_clock_div
	import eeprom_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic prescale_by_eight,
	input wire logic [5:0] divider_value,
	output logic algo_tick
);
	logic [2:0] pre_cnt;
	logic [5:0] div_cnt;
	wire pre_tick = !prescale_by_eight || (pre_cnt == prescale_count);
	wire div_wrap = pre_tick && (div_cnt == divider_value);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre_cnt <= 3'h0;
			div_cnt <= 6'h00;
			algo_tick <= 1'b0;
		end
		else if (!enable)
		begin
			pre_cnt <= 3'h0;
			div_cnt <= 6'h00;
			algo_tick <= 1'b0;
		end
		else
		begin
			pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
			if (pre_tick)
				div_cnt <= div_wrap ? 6'h00 : div_cnt + 6'h01;
			algo_tick <= div_wrap;
		end
	end
endmodule // algo_clock_div

// *** core/eeprom_ctrl_regs.sv ***
// Purpose: Divider, config, protection and flag registers of EEPROM block
// Assumes: Synchronous byte register port, read data one cycle later
// Notes: Command engine reports through alter and done inputs
`timescale 1ns/1ps
module eeprom_ctrl_regs
	import eeprom_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] nv_protection_byte,
	input wire logic nv_valid,
	output logic nv_fetch,
	input wire alter_req_t alter_req,
	output logic alter_grant,
	input wire logic buffer_emptied,
	input wire logic all_commands_done,
	output logic buffer_empty_irq,
	output logic command_done_irq,
	output logic algo_tick,
	output logic divider_loaded
);
	// ==========================================================
	// Register state
	logic [6:0] divider_bits;
	logic buffer_empty_irq_enable;
	logic command_done_irq_enable;
	logic open_for_program;
	logic [2:0] user_nonvolatile_flags;
	logic range_disable;
	logic [2:0] protected_size_code;
	logic buffer_empty_flag;
	logic command_done_flag;
	logic protection_violation_flag;
	prot_state_t state;
	prot_state_t next_state;

	// ==========================================================
	// Decode
	wire wr_div = reg_wr && (reg_addr == off_divider);
	wire wr_cfg = reg_wr && (reg_addr == off_config);
	wire wr_prot = reg_wr && (reg_addr == off_protection) &&
		(state == st_run);
	wire wr_stat = reg_wr && (reg_addr == off_status);
	wire clr_buf = wr_stat && reg_wdata[bit_buf_empty];
	wire clr_viol = wr_stat && reg_wdata[bit_viol];

	// ==========================================================
	// Protection check
	wire [10:0] sector_base = {2'b11, ~protected_size_code, 6'h00};
	wire in_sector = (alter_req.addr >= sector_base) &&
		(alter_req.addr <= array_top_addr);
	wire sector_hit = !range_disable && in_sector;
	wire mass_ok = open_for_program && range_disable;
	wire alter_ok = alter_req.mass ? mass_ok :
		(open_for_program && !sector_hit);
	wire violation = alter_req.valid && !alter_ok;
	assign alter_grant = alter_req.valid && alter_ok && (state == st_run) &&
		!protection_violation_flag;

	// ==========================================================
	// Reset load of protection byte
	assign nv_fetch = (state == st_load);
	always_comb
	begin
		next_state = state;
		case (state)
			st_idle: next_state = st_load;
			st_load: if (nv_valid) next_state = st_run;
			st_run: next_state = st_run;
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= st_idle;
		else
			state <= next_state;
	end

	// ==========================================================
	// Divider register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			divider_bits <= divider_reset[6:0];
			divider_loaded <= divider_reset[bit_loaded];
		end
		else if (wr_div && !divider_loaded)
		begin
			divider_bits <= reg_wdata[6:0];
			divider_loaded <= 1'b1;
		end
	end

	algo_clock_div u_div (
		.clk(clk),
		.arst_n(arst_n),
		.enable(divider_loaded),
		.prescale_by_eight(divider_bits[bit_prescale]),
		.divider_value(divider_bits[5:0]),
		.algo_tick(algo_tick)
	);

	// ==========================================================
	// Config register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			{buffer_empty_irq_enable, command_done_irq_enable} <= config_reset;
		else if (wr_cfg)
			{buffer_empty_irq_enable, command_done_irq_enable} <=
				reg_wdata[7:6];
	end

	// ==========================================================
	// Protection register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			open_for_program <= 1'b0;
			user_nonvolatile_flags <= 3'h0;
			range_disable <= 1'b0;
			protected_size_code <= 3'h0;
		end
		else if (state == st_load && nv_valid)
		begin
			open_for_program <= nv_protection_byte[bit_open];
			user_nonvolatile_flags <= nv_protection_byte[6:4];
			range_disable <= nv_protection_byte[bit_range_dis];
			protected_size_code <= nv_protection_byte[2:0];
		end
		else if (wr_prot)
		begin
			open_for_program <= open_for_program &
				reg_wdata[bit_open];
			range_disable <= range_disable &
				reg_wdata[bit_range_dis];
			if (range_disable)
				protected_size_code <= reg_wdata[2:0];
		end
	end

	// ==========================================================
	// Status flags, set wins over clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			buffer_empty_flag <= 1'b1;
			command_done_flag <= 1'b1;
			protection_violation_flag <= 1'b0;
		end
		else
		begin
			if (buffer_emptied)
				buffer_empty_flag <= 1'b1;
			else if (clr_buf)
				buffer_empty_flag <= 1'b0;
			if (all_commands_done)
				command_done_flag <= 1'b1;
			else if (clr_buf)
				command_done_flag <= 1'b0;
			if (violation)
				protection_violation_flag <= 1'b1;
			else if (clr_viol)
				protection_violation_flag <= 1'b0;
		end
	end

	assign buffer_empty_irq = buffer_empty_irq_enable &&
		buffer_empty_flag;
	assign command_done_irq = command_done_irq_enable &&
		command_done_flag;

	// ==========================================================
	// Read mux
	wire [7:0] rd_div = {divider_loaded, divider_bits};
	wire [7:0] rd_cfg = {buffer_empty_irq_enable, command_done_irq_enable,
		6'h00};
	wire [7:0] rd_prot = {open_for_program, user_nonvolatile_flags,
		range_disable, protected_size_code};
	wire [7:0] rd_stat = {buffer_empty_flag, command_done_flag,
		protection_violation_flag, 5'h00};
	wire [7:0] rd_sel =
		(reg_addr == off_divider) ? rd_div :
		(reg_addr == off_config) ? rd_cfg :
		(reg_addr == off_protection) ? rd_prot :
		(reg_addr == off_status) ? rd_stat :
		zero_byte;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= zero_byte;
		else if (reg_rd)
			reg_rdata <= rd_sel;
		else
			reg_rdata <= zero_byte;
	end
endmodule // eeprom_ctrl_regs

// *** sim/nv_byte_source.sv ***
// Purpose: Model of the nonvolatile protection byte feeding the register block
// Assumes: Byte arrives some cycles after the fetch request
// Notes: Byte lines carry a changing pattern until valid
`timescale 1ns/1ps
module nv_byte_source
	import eeprom_ctrl_pkg::*;
#(
	parameter logic [7:0] stored_byte = 8'hb8,
	parameter logic [3:0] lag = 4'h3
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic nv_fetch,
	output logic [7:0] nv_protection_byte,
	output logic nv_valid
);
	logic [3:0] cnt;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			cnt <= 4'h0;
		else if (nv_fetch && cnt != lag)
			cnt <= cnt + 4'h1;
	assign nv_valid = nv_fetch && cnt == lag;
	assign nv_protection_byte = nv_valid ? stored_byte :
		~stored_byte ^ {4'h0, cnt};
endmodule // nv_byte_source

// *** sim/eeprom_ctrl_regs_monitor.sv ***
// Purpose: Port checker for the EEPROM control registers
// Assumes: One clock domain, bound to the register block
// Notes: Read data follow the read strobe by one cycle
`timescale 1ns/1ps
module eeprom_ctrl_regs_monitor
	import eeprom_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic nv_fetch,
	input wire alter_req_t alter_req,
	input wire logic alter_grant,
	input wire logic buffer_empty_irq,
	input wire logic command_done_irq,
	input wire logic algo_tick,
	input wire logic divider_loaded
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_rsvd;
		$past(reg_rd && (reg_addr == off_reserved_a ||
			reg_addr == off_reserved_b)) |-> reg_rdata == zero_byte;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved read not zero");
	property p_cfg_zero;
		$past(reg_rd && reg_addr == off_config) |->
			reg_rdata[5:0] == 6'h00;
	endproperty
	a_cfg_zero: assert property (p_cfg_zero)
		else $error("config low bits set");
	property p_loaded_hold;
		divider_loaded |=> divider_loaded [*3];
	endproperty
	a_loaded_hold: assert property (p_loaded_hold)
		else $error("loaded bit fell");
	property p_loaded_cause;
		$rose(divider_loaded) |->
			$past(reg_wr && reg_addr == off_divider);
	endproperty
	a_loaded_cause: assert property (p_loaded_cause)
		else $error("loaded without write");
	property p_loaded_read;
		$past(reg_rd && reg_addr == off_divider) |->
			reg_rdata[bit_loaded] == $past(divider_loaded);
	endproperty
	a_loaded_read: assert property (p_loaded_read)
		else $error("loaded bit misread");
	property p_buf_irq_off;
		$past(reg_wr && reg_addr == off_config &&
			!reg_wdata[bit_buf_irq_en]) |-> !buffer_empty_irq;
	endproperty
	a_buf_irq_off: assert property (p_buf_irq_off)
		else $error("buffer irq while off");
	property p_done_irq_off;
		$past(reg_wr && reg_addr == off_config &&
			!reg_wdata[bit_done_irq_en]) |-> !command_done_irq;
	endproperty
	a_done_irq_off: assert property (p_done_irq_off)
		else $error("done irq while off");
	property p_fetch_no_grant;
		nv_fetch |-> !alter_grant;
	endproperty
	a_fetch_no_grant: assert property (p_fetch_no_grant)
		else $error("grant before load");
	property p_tick_wait;
		!divider_loaded |-> !algo_tick;
	endproperty
	a_tick_wait: assert property (p_tick_wait)
		else $error("tick before divider");
endmodule // eeprom_ctrl_regs_monitor
bind eeprom_ctrl_regs eeprom_ctrl_regs_monitor u_mon (.clk, .arst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_fetch, .alter_req, .alter_grant,
	.buffer_empty_irq, .command_done_irq, .algo_tick, .divider_loaded);

// *** sim/eeprom_ctrl_regs_tb_top.sv ***
// Purpose: Register level test of the EEPROM control block
// Assumes: Protection byte model answers after three cycles
// Notes: Divider gives 504 clocks per algorithm tick, 198 kHz at 100 MHz
`timescale 1ns/1ps
module eeprom_ctrl_regs_tb_top;
	import eeprom_ctrl_pkg::*;
	logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, nv_valid, nv_fetch;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, nv_protection_byte;
	alter_req_t alter_req = '0;
	logic alter_grant, buffer_emptied = 0, all_commands_done = 0;
	logic buffer_empty_irq, command_done_irq, algo_tick, divider_loaded;
	int n_errors = 0, tests_run = 0, cyc = 0, n;
	always #5 clk = ~clk;
	eeprom_ctrl_regs dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .nv_protection_byte, .nv_valid, .nv_fetch, .alter_req,
		.alter_grant, .buffer_emptied, .all_commands_done, .buffer_empty_irq,
		.command_done_irq, .algo_tick, .divider_loaded);
	nv_byte_source nv (.clk, .arst_n, .nv_fetch, .nv_protection_byte, .nv_valid);
	// ==========================================
	// Tasks
	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("read", e, reg_rdata);
	endtask
	task automatic al(input logic m, input logic [10:0] a, input logic e);
		@(posedge clk);
		alter_req <= '{1'b1, m, a};
		#1 chk("grant", {7'h0, e}, {7'h0, alter_grant});
		@(posedge clk);
		alter_req <= '0;
	endtask
	function automatic logic [7:0] irqs();
		return {6'h0, buffer_empty_irq, command_done_irq};
	endfunction
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========================================
	// Sequence
	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		for (n = 0; n < 2 || (nv_fetch !== 1'b0 && n < 50); n++) @(posedge clk);
		rd(off_protection, 8'hb8);
		wr(off_protection, 8'h8f);
		rd(off_protection, 8'hbf);
		al(1'b0, 11'h7ff, 1'b1);
		al(1'b0, protection_byte_addr, 1'b1);
		al(1'b1, 11'h000, 1'b1);
		wr(off_protection, 8'hb5);
		wr(off_protection, 8'hb0);
		rd(off_protection, 8'hb5);
		al(1'b0, 11'h67f, 1'b1);
		al(1'b0, 11'h680, 1'b0);
		rd(off_status, 8'he0);
		wr(off_status, 8'h20);
		al(1'b1, 11'h000, 1'b0);
		wr(off_status, 8'h20);
		wr(off_protection, 8'h30);
		rd(off_protection, 8'h35);
		al(1'b0, 11'h000, 1'b0);
		wr(off_protection, 8'hff);
		rd(off_protection, 8'h35);
		rd(off_divider, 8'h00);
		wr(off_divider, 8'h7e);
		wr(off_divider, 8'h01);
		rd(off_divider, 8'hfe);
		for (n = 0; n < 600 && algo_tick !== 1'b1; n++) @(posedge clk) #1;
		for (n = 1; n < 600 && algo_tick !== 1'b0; n++) @(posedge clk) #1;
		for (n = 1; n < 600 && algo_tick !== 1'b1; n++) @(posedge clk) #1;
		tests_run++;
		if (n !== 8 * (62 + 1))
		begin
			n_errors++;
			$display("Error tick gap expected %0d seen %0d", 8 * (62 + 1), n);
		end
		for (n = 1; n < 3; n++)
		begin
			wr(4'(n), 8'hff);
			rd(4'(n), 8'h00);
		end
		wr(off_config, 8'hff);
		rd(off_config, 8'hc0);
		chk("irq", 8'h03, irqs());
		wr(off_config, 8'h80);
		#1 chk("irq", 8'h02, irqs());
		wr(off_status, 8'h80);
		#1 chk("irq", 8'h00, irqs());
		@(posedge clk) buffer_emptied <= 1'b1;
		@(posedge clk) buffer_emptied <= 1'b0;
		#1 chk("irq", 8'h02, irqs());
		wr(off_config, 8'h40);
		@(posedge clk) all_commands_done <= 1'b1;
		@(posedge clk) all_commands_done <= 1'b0;
		#1 chk("irq", 8'h01, irqs());
		end_of_test();
	end
endmodule // eeprom_ctrl_regs_tb_top
